// File: agp_aux_gpio.sv
// Aux pin and input precharge buffer register block
`timescale 1ns/1ps
module agp_aux_gpio #(
  parameter logic [7:0] SILICON_REV_CODE = 8'h5A // Arbitrary value
) (
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire agp_pkg::agp_req_t        req,
  output agp_pkg::agp_rsp_t             rsp,
  input  wire logic                     serial_ctrl_mode,
  input  wire logic [4:0]               shared_pin_in,
  output agp_pkg::agp_pin_drive_t       pin_drive,
  output logic [4:0]                    dedicated_pin_level,
  output logic                          aux_pins_global_enable,
  output logic                          ch1_neg_input_buffer_on,
  output logic                          ch1_pos_input_buffer_on,
  output logic                          ch0_neg_input_buffer_on,
  output logic                          ch0_pos_input_buffer_on
);

  logic [7:0] pin_enable_direction;
  logic [7:0] pin_output_levels;
  logic [4:0] pin_input_levels;
  logic [7:0] input_prebuffer_ch01;
  logic [4:0] pin_sampled;
  logic       gpio_active;
  logic [4:0] pin_is_output;
  logic [7:0] next_rdata;

  agp_pin_sync u_sync (
    .clk       (clk),
    .rst_n     (rst_n),
    .pin_async (shared_pin_in),
    .pin_level (pin_sampled)
  );

  // ------------------------------------------------------------------
  // Mode decode
  // ------------------------------------------------------------------
  // Pin-control mode keeps the dedicated function regardless of bit 7
  assign gpio_active = serial_ctrl_mode
                     & pin_enable_direction[agp_pkg::AGP_GLOBAL_EN_BIT];
  assign pin_is_output = {5{gpio_active}}
                       & pin_enable_direction[4:0];

  // Read-only and unmapped addresses never hit a writable register
  function automatic logic wr_hit(input agp_pkg::agp_req_t req_in,
                                  input logic [7:0]        addr_in);
    return req_in.wr_en && (req_in.addr == addr_in);
  endfunction

  // ------------------------------------------------------------------
  // Writable registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_enable_direction <= agp_pkg::AGP_PIN_CTRL_RESET;
    end else if (wr_hit(req, agp_pkg::AGP_REG_PIN_CTRL)) begin
      pin_enable_direction <= req.wdata & agp_pkg::AGP_CTRL_WR_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_output_levels <= agp_pkg::AGP_PIN_OUT_RESET;
    end else if (wr_hit(req, agp_pkg::AGP_REG_PIN_OUT)) begin
      pin_output_levels <= req.wdata & agp_pkg::AGP_OUT_WR_MASK;
    end
  end

  // Stored inverted so software writes the complement of the wanted enables
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      input_prebuffer_ch01 <= agp_pkg::AGP_PREBUF_RESET;
    end else if (wr_hit(req, agp_pkg::AGP_REG_PREBUF_CH01)) begin
      input_prebuffer_ch01 <= ~req.wdata;
    end
  end

  // ------------------------------------------------------------------
  // Input level capture
  // ------------------------------------------------------------------
  // Only input-configured pins update; others hold their last sample
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_input_levels <= agp_pkg::AGP_PIN_IN_RESET;
    end else begin
      for (int i = 0; i < agp_pkg::AGP_NUM_PINS; i++) begin
        if (gpio_active && !pin_enable_direction[i]) begin
          pin_input_levels[i] <= pin_sampled[i];
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------------
  always_comb begin
    unique case (req.addr)
      agp_pkg::AGP_REG_REVISION:    next_rdata = SILICON_REV_CODE;
      agp_pkg::AGP_REG_PIN_CTRL:    next_rdata = pin_enable_direction;
      agp_pkg::AGP_REG_PIN_OUT:     next_rdata = pin_output_levels;
      agp_pkg::AGP_REG_PIN_IN:      next_rdata = {3'h0, pin_input_levels};
      agp_pkg::AGP_REG_PREBUF_CH01: next_rdata = input_prebuffer_ch01;
      default:                      next_rdata = agp_pkg::AGP_READ_ZERO;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rsp <= '0;
    end else begin
      rsp.rvalid <= req.rd_en;
      rsp.rdata  <= req.rd_en ? next_rdata : agp_pkg::AGP_READ_ZERO;
    end
  end

  // ------------------------------------------------------------------
  // Pin drivers and block outputs
  // ------------------------------------------------------------------
  // Enable is active low; all drivers off while the global enable is clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_drive.out_level <= agp_pkg::AGP_LEVEL_RESET;
      pin_drive.oe_n      <= agp_pkg::AGP_OE_N_RESET;
    end else begin
      pin_drive.out_level <= pin_output_levels[4:0] & pin_is_output;
      pin_drive.oe_n      <= ~pin_is_output;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dedicated_pin_level    <= agp_pkg::AGP_PIN_IN_RESET;
      aux_pins_global_enable <= agp_pkg::AGP_GLOBAL_EN_RESET;
    end else begin
      dedicated_pin_level    <= pin_sampled;
      aux_pins_global_enable <= gpio_active;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      {ch1_neg_input_buffer_on, ch1_pos_input_buffer_on,
       ch0_neg_input_buffer_on,
       ch0_pos_input_buffer_on} <= agp_pkg::AGP_BUF_ON_RESET;
    end else begin
      {ch1_neg_input_buffer_on, ch1_pos_input_buffer_on,
       ch0_neg_input_buffer_on,
       ch0_pos_input_buffer_on} <= input_prebuffer_ch01[3:0];
    end
  end

endmodule

// File: agp_pkg.sv
// Package with register map, field layout and reset values for the aux pins
// What this block does
// - Read-only 8-bit revision code register
// - Pins are general purpose only in serial mode
// - Global pin enable resets to zero
// - Control bit 7 enables all five pins
// - Control bits 4..0 set direction, 1 output
// - Direction bit n steers shared pin n
// - Output data bits drive output pins
// - Input data bits show sampled input pins
// - Control, output, input registers reset zero
// - Precharge register stores inverse of written data
// - Precharge bits 3..0 enable channel 0/1 buffers
// - Precharge register resets to all ones
package agp_pkg;

  localparam logic [7:0] AGP_REG_REVISION     = 8'h0A;
  localparam logic [7:0] AGP_REG_PIN_CTRL     = 8'h0E;
  localparam logic [7:0] AGP_REG_PIN_OUT      = 8'h0F;
  localparam logic [7:0] AGP_REG_PIN_IN       = 8'h10;
  localparam logic [7:0] AGP_REG_PREBUF_CH01  = 8'h11;

  localparam int         AGP_NUM_PINS         = 5;
  localparam int         AGP_GLOBAL_EN_BIT    = 7;

  localparam logic [7:0] AGP_PIN_CTRL_RESET   = 8'h00;
  localparam logic [7:0] AGP_PIN_OUT_RESET    = 8'h00;
  localparam logic [4:0] AGP_PIN_IN_RESET     = 5'h00;
  localparam logic [7:0] AGP_PREBUF_RESET     = 8'hFF;
  localparam logic [7:0] AGP_READ_ZERO        = 8'h00;
  localparam logic [2:0] AGP_SYNC_RESET       = 3'h0;
  localparam logic [7:0] AGP_CTRL_WR_MASK     = 8'h9F;
  localparam logic [7:0] AGP_OUT_WR_MASK      = 8'h1F;
  localparam logic [4:0] AGP_LEVEL_RESET      = 5'h00;
  localparam logic [4:0] AGP_OE_N_RESET       = 5'h1F;
  localparam logic [3:0] AGP_BUF_ON_RESET     = 4'hF;
  localparam logic       AGP_GLOBAL_EN_RESET  = 1'h0;

  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } agp_req_t;

  typedef struct packed {
    logic       rvalid;
    logic [7:0] rdata;
  } agp_rsp_t;

  typedef struct packed {
    logic [4:0] out_level;
    logic [4:0] oe_n;
  } agp_pin_drive_t;

endpackage

// File: agp_pin_sync.sv
// Three-stage input synchroniser for the shared pins
`timescale 1ns/1ps
module agp_pin_sync (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [4:0] pin_async,
  output logic [4:0]      pin_level
);

  logic [4:0] stage1;
  logic [4:0] stage2;
  logic [4:0] stage3;

  // ------------------------------------------------------------------
  // Synchroniser chain
  // ------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage1 <= agp_pkg::AGP_PIN_IN_RESET;
      stage2 <= agp_pkg::AGP_PIN_IN_RESET;
      stage3 <= agp_pkg::AGP_PIN_IN_RESET;
    end else begin
      stage1 <= pin_async;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // A bit only moves once stages two and three agree, filtering one glitch
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_level <= agp_pkg::AGP_PIN_IN_RESET;
    end else begin
      for (int i = 0; i < agp_pkg::AGP_NUM_PINS; i++) begin
        if (stage2[i] == stage3[i]) begin
          pin_level[i] <= stage3[i];
        end
      end
    end
  end

endmodule

// File: agp_aux_gpio_assertions.sv
// Port checker for the aux pin and precharge block
`timescale 1ns/1ps
module agp_aux_gpio_assertions #(
  parameter logic [7:0] SILICON_REV_CODE = 8'h5A // Arbitrary value
) (
  input wire logic                    clk,
  input wire logic                    rst_n,
  input wire agp_pkg::agp_req_t       req,
  input wire agp_pkg::agp_rsp_t       rsp,
  input wire logic                    serial_ctrl_mode,
  input wire agp_pkg::agp_pin_drive_t pin_drive,
  input wire logic                    aux_pins_global_enable,
  input wire logic                    ch1_neg_input_buffer_on,
  input wire logic                    ch1_pos_input_buffer_on,
  input wire logic                    ch0_neg_input_buffer_on,
  input wire logic                    ch0_pos_input_buffer_on
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire [3:0] bufs = {ch1_neg_input_buffer_on, ch1_pos_input_buffer_on,
                     ch0_neg_input_buffer_on, ch0_pos_input_buffer_on};
  wire       wr_buf = req.wr_en && req.addr == 8'h11;
  a_rd_answer: assert property (req.rd_en |=> rsp.rvalid)
    else $error("read not answered");
  a_rv_cause: assert property (rsp.rvalid |-> $past(req.rd_en))
    else $error("answer without read");
  a_rev_value: assert property (req.rd_en && req.addr == 8'h0A |=>
    rsp.rdata == SILICON_REV_CODE) else $error("wrong revision code");
  a_rdata_idle: assert property (!rsp.rvalid |-> rsp.rdata == 8'h00)
    else $error("read data outside answer");
  a_tri_off: assert property (!aux_pins_global_enable |->
    pin_drive.oe_n == 5'h1F) else $error("driving while disabled");
  a_out_masked: assert property ((pin_drive.out_level & pin_drive.oe_n)
    == 5'h00) else $error("level on undriven pin");
  a_gen_mode: assert property (aux_pins_global_enable |->
    $past(serial_ctrl_mode)) else $error("enable in pin mode");
  a_buf_cause: assert property ($changed(bufs) |->
    $past(wr_buf) || $past(wr_buf, 2)) else $error("buffer change");
  a_buf_follow: assert property (wr_buf |=> ##1
    bufs == ~$past(req.wdata[3:0], 2)) else $error("buffer not inverse");
endmodule

// File: agp_host_model.sv
// Host port model issuing single-byte register accesses
`timescale 1ns/1ps
module agp_host_model (
  input  wire logic              clk,
  input  wire agp_pkg::agp_rsp_t rsp,
  output agp_pkg::agp_req_t      req
);
  initial req = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    req <= '0;
  endtask
  // Answer is taken one edge after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [8:0] q);
    @(posedge clk);
    req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
    q = {rsp.rvalid, rsp.rdata};
  endtask
endmodule

// File: adc_aux_gpio_and_prebuf_regs_tb.sv
// Testbench for the aux pin and precharge registers
`timescale 1ns/1ps
module adc_aux_gpio_and_prebuf_regs_tb;
  localparam logic [7:0] REV = 8'h3C; // Arbitrary value
  logic                    clk = 1'b0;
  logic                    rst_n = 1'b0;
  logic                    mode = 1'b0;
  logic [4:0]              pins = 5'h00;
  wire [4:0]               ded;
  wire [3:0]               bufs;
  wire                     gen;
  agp_pkg::agp_req_t       req;
  agp_pkg::agp_rsp_t       rsp;
  agp_pkg::agp_pin_drive_t drv;
  int                      fails = 0;
  int                      checked = 0;
  agp_host_model agp_host_model_i (.clk(clk), .rsp(rsp), .req(req));
  agp_aux_gpio #(.SILICON_REV_CODE(REV)) agp_aux_gpio_i (.clk(clk),
    .rst_n(rst_n), .req(req), .rsp(rsp), .serial_ctrl_mode(mode),
    .shared_pin_in(pins), .pin_drive(drv), .dedicated_pin_level(ded),
    .aux_pins_global_enable(gen), .ch1_neg_input_buffer_on(bufs[3]),
    .ch1_pos_input_buffer_on(bufs[2]), .ch0_neg_input_buffer_on(bufs[1]),
    .ch0_pos_input_buffer_on(bufs[0]));
  initial forever #5 clk = ~clk;
  task automatic end_sim();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk_pin(string n, logic [9:0] e, logic [9:0] g);
    checked++;
    if (e !== g) begin
      fails++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk_rd(string n, logic [7:0] a, logic [8:0] e);
    logic [8:0] q;
    agp_host_model_i.rd(a, q);
    chk_pin(n, {1'b0, e}, {1'b0, q});
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    agp_host_model_i.wr(a, d);
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic t_reset();
    chk_rd("rev", 8'h0A, {1'b1, REV});
    chk_rd("ctrl", 8'h0E, 9'h100);
    chk_rd("out", 8'h0F, 9'h100);
    chk_rd("in", 8'h10, 9'h100);
    chk_rd("prebuf", 8'h11, 9'h1FF);
    chk_rd("unmapped", 8'h0B, 9'h100);
    chk_pin("drive", 10'h01F, drv);
  endtask
  task automatic t_prebuf();
    for (int i = 0; i < 4; i++) begin
      wr(8'h11, 8'h01 << i);
      chk_rd("prebuf", 8'h11, {1'b1, ~(8'h01 << i)});
      chk_pin("bufs", {6'h00, ~(4'h1 << i)}, {6'h00, bufs});
    end
  endtask
  task automatic t_out();
    @(posedge clk);
    mode <= 1'b1;
    wr(8'h0E, 8'hFF);
    chk_rd("ctrl", 8'h0E, 9'h19F);
    chk_pin("enable", 10'h001, {9'h000, gen});
    wr(8'h0F, 8'hF5);
    chk_rd("out", 8'h0F, 9'h115);
    chk_pin("drive", 10'h2A0, drv);
    wr(8'h0E, 8'h90);
    chk_pin("drive", 10'h20F, drv);
    wr(8'h0E, 8'h81);
    chk_pin("drive", 10'h03E, drv);
    wr(8'h0E, 8'h1F);
    chk_pin("drive", 10'h01F, drv);
    wr(8'h0E, 8'h9F);
    @(posedge clk);
    mode <= 1'b0;
    wr(8'h0F, 8'h15);
    chk_pin("drive", 10'h01F, drv);
    chk_pin("enable", 10'h000, {9'h000, gen});
  endtask
  task automatic t_in();
    @(posedge clk);
    mode <= 1'b1;
    pins <= 5'h0B;
    wr(8'h0E, 8'h80);
    wr(8'h10, 8'h00);
    wr(8'h0A, 8'h00);
    chk_rd("in", 8'h10, 9'h10B);
    chk_rd("rev", 8'h0A, {1'b1, REV});
    chk_pin("dedicated", 10'h00B, {5'h00, ded});
  endtask
  task automatic t_rerun();
    wr(8'h0E, 8'h9F);
    wr(8'h11, 8'h0F);
    chk_pin("bufs", 10'h000, {6'h00, bufs});
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    chk_rd("ctrl", 8'h0E, 9'h100);
    chk_rd("prebuf", 8'h11, 9'h1FF);
    chk_pin("bufs", 10'h00F, {6'h00, bufs});
    chk_pin("drive", 10'h01F, drv);
    chk_pin("enable", 10'h000, {9'h000, gen});
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_prebuf();
    t_out();
    t_in();
    t_rerun();
    end_sim();
  end
  initial begin
    #50000;
    fails++;
    end_sim();
  end
endmodule
bind agp_aux_gpio agp_aux_gpio_assertions
  #(.SILICON_REV_CODE(SILICON_REV_CODE))
  agp_aux_gpio_assertions_i (.clk(clk), .rst_n(rst_n), .req(req),
  .rsp(rsp), .serial_ctrl_mode(serial_ctrl_mode), .pin_drive(pin_drive),
  .aux_pins_global_enable(aux_pins_global_enable),
  .ch1_neg_input_buffer_on(ch1_neg_input_buffer_on),
  .ch1_pos_input_buffer_on(ch1_pos_input_buffer_on),
  .ch0_neg_input_buffer_on(ch0_neg_input_buffer_on),
  .ch0_pos_input_buffer_on(ch0_pos_input_buffer_on));
